// file: hw/eimg_top.sv
// encoder module input image: telegram exchange, register access, live status
//
// Overview of operation
// - read data is register value, zero if refused
// - read-refused flag clear on success, else set
// - echo six-bit read address in image
// - read value placed in input bytes 0-3
// - write-done flag reports whether write succeeded
// - request high: busy flag high, no new job
// - request low: busy flag low, job accepted next
// - forward four encoder status bits
// - count-up set while position increases
// - count-down set while position decreases
// - compare bit set when position >= second value
// - status bits always show present condition
// - flags hold their value until the next telegram
// - input telegram is eight bytes, fixed layout
// - encoder byte carries write done and busy
//
// ----------------------------------------
// timing at the ports
// ----------------------------------------
// telegram taken on the edge with telStrobe high
// read and write fields answer one cycle later
// telInValid stands for that one cycle only
// read fields hold until the next telegram
// a read in a write telegram sees the old value
// encoder status shows one cycle after the pins
// up and down show two cycles after a sample
// compare bit trails the position by two cycles
// software read data stands one cycle, else zero
//
// ----------------------------------------
// limits
// ----------------------------------------
// controller registers: 0 position, 1 compare, 2 spare
// addresses 3 to 63 refused for read and write
// software control gates telegram reads and writes
// a new write job needs a request-low telegram first
// counters stop at all ones rather than wrap
// byte 7 and unused bits of bytes 4 to 6 read zero
`timescale 1ns/1ns

module eimg_top (
	input wire logic ref_clk, // 50 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic telStrobe, // one-cycle pulse: output image valid
	input wire logic [63:0] telOut, // controller output image, byte n at [8n+7:8n]
	output logic [63:0] telIn, // input image returned to controller
	output logic telInValid, // one-cycle pulse: input image refreshed
	input wire logic [31:0] encPos, // current_position_value from encoder
	input wire logic encPosValid, // one-cycle pulse: new position sample
	input wire logic [3:0] encStatus, // encoder_status_bit3..0
	input wire logic [7:0] swAddr, // software port byte address
	input wire logic [31:0] swWrData, // software write data
	input wire logic swWr, // software write strobe
	input wire logic swRd, // software read strobe
	output logic [31:0] swRdData // software read data, cycle after strobe
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	eimg_bank_if bankBus ();
	eimg_cmp_if cmpBus ();

	eimg_pkg::eimg_wr_state_t wrStateQ;
	logic [31:0] posQ;
	logic posValidQ;
	logic [31:0] rdDataQ;
	logic [5:0] rdAdrQ;
	logic rdAbortQ;
	logic writeDoneOkQ;
	logic writeHandshakeBusyQ;
	logic [3:0] encStsQ;
	logic countingUpwardQ;
	logic countingDownwardQ;
	logic atOrAboveCmp2Q;
	logic telInValidQ;
	logic [1:0] ctrlQ;
	logic [15:0] rdRefCntQ;
	logic [15:0] wrRefCntQ;
	logic [15:0] telCntQ;
	logic [31:0] swRdDataQ;

	logic wrReq;
	logic [5:0] wrAdr;
	logic [5:0] rdAdr;
	logic [31:0] wrData;
	logic jobStart;
	logic writeAllowed;
	logic readAllowed;
	logic rdGranted;
	logic wrGranted;

	// ----------------------------------------
	// output image decode
	// ----------------------------------------
	// request bit, addresses and data come from fixed byte slots
	assign wrReq = telOut[eimg_pkg::OUT_WR_BYTE * 8 + eimg_pkg::WR_REQ_BIT];
	assign wrAdr = telOut[eimg_pkg::OUT_WR_BYTE * 8 +: eimg_pkg::ADR_W];
	assign rdAdr = telOut[eimg_pkg::OUT_RD_BYTE * 8 +: eimg_pkg::ADR_W];
	assign wrData = telOut[eimg_pkg::OUT_DATA_BYTE * 8 +: eimg_pkg::DATA_W];
	assign writeAllowed = ctrlQ[eimg_pkg::CTRL_WR_EN_BIT];
	assign readAllowed = ctrlQ[eimg_pkg::CTRL_RD_EN_BIT];

	// a job is only taken while the handshake is idle
	assign jobStart = telStrobe && wrReq && (wrStateQ == eimg_pkg::WR_IDLE);
	assign wrGranted = jobStart && writeAllowed && bankBus.wrOk;
	assign rdGranted = readAllowed && bankBus.rdOk;

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	// bank sees the raw telegram; the top decides what is granted
	assign bankBus.wrEn = wrGranted;
	assign bankBus.wrAdr = wrAdr;
	assign bankBus.wrData = wrData;
	assign bankBus.rdAdr = rdAdr;
	assign bankBus.posVal = posQ;

	eimg_regbank uBank (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.bus(bankBus)
	);

	// ----------------------------------------
	// position compare
	// ----------------------------------------
	// valid trails the sample by one edge so the compare sees the new position
	assign cmpBus.posVal = posQ;
	assign cmpBus.posValid = posValidQ;
	assign cmpBus.cmp2Val = bankBus.cmp2Val;

	eimg_compare uCmp (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cmp(cmpBus)
	);

	// ----------------------------------------
	// encoder sampling
	// ----------------------------------------
	// position held between samples so reads return a stable value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			posQ <= 32'h0000_0000;
		end else if (encPosValid) begin
			posQ <= encPos;
		end
	end

	// marks the cycle in which posQ holds a fresh sample
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			posValidQ <= 1'b0;
		end else begin
			posValidQ <= encPosValid;
		end
	end

	// ----------------------------------------
	// write handshake
	// ----------------------------------------
	// held until the controller drops its request, so one request gives one write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrStateQ <= eimg_pkg::WR_IDLE;
		end else if (telStrobe) begin
			case (wrStateQ)
				eimg_pkg::WR_IDLE: begin
					if (wrReq) begin
						wrStateQ <= eimg_pkg::WR_HELD;
					end
				end
				eimg_pkg::WR_HELD: begin
					if (!wrReq) begin
						wrStateQ <= eimg_pkg::WR_IDLE;
					end
				end
				default: begin
					wrStateQ <= eimg_pkg::WR_IDLE;
				end
			endcase
		end
	end

	// busy flag mirrors the request bit of the latest telegram
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			writeHandshakeBusyQ <= 1'b0;
		end else if (telStrobe) begin
			writeHandshakeBusyQ <= wrReq;
		end
	end

	// result of the last job stays until the next job replaces it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			writeDoneOkQ <= 1'b0;
		end else if (jobStart) begin
			writeDoneOkQ <= wrGranted;
		end
	end

	// ----------------------------------------
	// read back
	// ----------------------------------------
	// a refused read returns zero so stale data is never mistaken for valid
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdDataQ <= 32'h0000_0000;
			rdAdrQ <= 6'h00;
			rdAbortQ <= 1'b0;
		end else if (telStrobe) begin
			rdDataQ <= rdGranted ? bankBus.rdData : 32'h0000_0000;
			rdAbortQ <= !rdGranted;
			rdAdrQ <= rdAdr;
		end
	end

	// ----------------------------------------
	// live status
	// ----------------------------------------
	// sampled every cycle, never latched, so the image shows the present state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			encStsQ <= 4'h0;
			countingUpwardQ <= 1'b0;
			countingDownwardQ <= 1'b0;
			atOrAboveCmp2Q <= 1'b0;
		end else begin
			encStsQ <= encStatus;
			countingUpwardQ <= cmpBus.up;
			countingDownwardQ <= cmpBus.down;
			atOrAboveCmp2Q <= cmpBus.atOrAbove;
		end
	end

	// ----------------------------------------
	// telegram refresh
	// ----------------------------------------
	// one pulse per exchange, one cycle after the output image
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			telInValidQ <= 1'b0;
		end else begin
			telInValidQ <= telStrobe;
		end
	end

	// image assembled from flops only; unused bits read zero
	always_comb begin
		telIn = 64'h0000_0000_0000_0000;
		telIn[0 +: eimg_pkg::DATA_W] = rdDataQ;
		telIn[eimg_pkg::IN_RD_ADR_BYTE * 8 +: eimg_pkg::ADR_W] = rdAdrQ;
		telIn[eimg_pkg::IN_RD_ADR_BYTE * 8 + eimg_pkg::RD_ABORT_BIT] = rdAbortQ;
		telIn[eimg_pkg::IN_ENC_BYTE * 8 +: eimg_pkg::ENC_STS_W] = encStsQ;
		telIn[eimg_pkg::IN_ENC_BYTE * 8 + eimg_pkg::WR_OK_BIT] = writeDoneOkQ;
		telIn[eimg_pkg::IN_ENC_BYTE * 8 + eimg_pkg::WR_BUSY_BIT] = writeHandshakeBusyQ;
		telIn[eimg_pkg::IN_CMP_BYTE * 8 + eimg_pkg::UP_BIT] = countingUpwardQ;
		telIn[eimg_pkg::IN_CMP_BYTE * 8 + eimg_pkg::DOWN_BIT] = countingDownwardQ;
		telIn[eimg_pkg::IN_CMP_BYTE * 8 + eimg_pkg::GE2_BIT] = atOrAboveCmp2Q;
	end

	assign telInValid = telInValidQ;

	// ----------------------------------------
	// software control and counters
	// ----------------------------------------
	// control bits gate the controller's access to the bank
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlQ <= eimg_pkg::CTRL_RST;
		end else if (swWr && swAddr == eimg_pkg::SW_CTRL) begin
			ctrlQ <= swWrData[1:0];
		end
	end

	// counters saturate rather than wrap, so a large count is never misread as small
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdRefCntQ <= 16'h0000;
			wrRefCntQ <= 16'h0000;
			telCntQ <= 16'h0000;
		end else begin
			if (telStrobe && !rdGranted && rdRefCntQ != 16'hFFFF) begin
				rdRefCntQ <= rdRefCntQ + 16'h0001;
			end
			if (jobStart && !wrGranted && wrRefCntQ != 16'hFFFF) begin
				wrRefCntQ <= wrRefCntQ + 16'h0001;
			end
			if (telStrobe && telCntQ != 16'hFFFF) begin
				telCntQ <= telCntQ + 16'h0001;
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			swRdDataQ <= 32'h0000_0000;
		end else if (swRd) begin
			case (swAddr)
				eimg_pkg::SW_CTRL: begin
					swRdDataQ <= {30'h0000_0000, ctrlQ};
				end
				eimg_pkg::SW_STATUS: begin
					swRdDataQ <= {16'h0000, telIn[eimg_pkg::IN_CMP_BYTE * 8 +: 8],
						telIn[eimg_pkg::IN_ENC_BYTE * 8 +: 8]};
				end
				eimg_pkg::SW_POS: begin
					swRdDataQ <= posQ;
				end
				eimg_pkg::SW_CMP2: begin
					swRdDataQ <= bankBus.cmp2Val;
				end
				eimg_pkg::SW_RD_REF: begin
					swRdDataQ <= {16'h0000, rdRefCntQ};
				end
				eimg_pkg::SW_WR_REF: begin
					swRdDataQ <= {16'h0000, wrRefCntQ};
				end
				eimg_pkg::SW_TEL_CNT: begin
					swRdDataQ <= {16'h0000, telCntQ};
				end
				default: begin
					swRdDataQ <= 32'h0000_0000;
				end
			endcase
		end else begin
			swRdDataQ <= 32'h0000_0000;
		end
	end

	assign swRdData = swRdDataQ;
endmodule

// file: shared/eimg_pkg.sv
// constants and types shared by the encoder input image block
package eimg_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int TEL_BYTES = 8;
	localparam int TEL_W = 64;
	localparam int DATA_W = 32;
	localparam int ADR_W = 6;
	localparam int ENC_STS_W = 4;

	// ----------------------------------------
	// input image layout (byte index, bit in byte)
	// ----------------------------------------
	localparam int IN_RD_ADR_BYTE = 4;
	localparam int IN_ENC_BYTE = 5;
	localparam int IN_CMP_BYTE = 6;
	localparam int IN_COMM_BYTE = 7;
	localparam int RD_ABORT_BIT = 7;
	localparam int WR_OK_BIT = 7;
	localparam int WR_BUSY_BIT = 6;
	localparam int UP_BIT = 0;
	localparam int DOWN_BIT = 1;
	localparam int GE2_BIT = 2;

	// ----------------------------------------
	// output image layout
	// ----------------------------------------
	localparam int OUT_WR_BYTE = 2;
	localparam int WR_REQ_BIT = 7;
	localparam int OUT_RD_BYTE = 3;
	localparam int OUT_DATA_BYTE = 4;

	// ----------------------------------------
	// register bank addresses seen by the controller
	// ----------------------------------------
	localparam logic [5:0] REG_POS_IDX = 6'h00;
	localparam logic [5:0] REG_RW_BASE = 6'h01;
	localparam int NUM_RW = 2;
	localparam logic [31:0] RW_RST = 32'h0000_0000;

	// ----------------------------------------
	// local software port offsets and reset values
	// ----------------------------------------
	localparam logic [7:0] SW_CTRL = 8'h00;
	localparam logic [7:0] SW_STATUS = 8'h04;
	localparam logic [7:0] SW_POS = 8'h08;
	localparam logic [7:0] SW_CMP2 = 8'h0C;
	localparam logic [7:0] SW_RD_REF = 8'h10;
	localparam logic [7:0] SW_WR_REF = 8'h14;
	localparam logic [7:0] SW_TEL_CNT = 8'h18;
	localparam int CTRL_WR_EN_BIT = 0;
	localparam int CTRL_RD_EN_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;

	// write handshake states
	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_HELD = 1'b1
	} eimg_wr_state_t;

endpackage

// file: shared/eimg_if.sv
// carriers between the image top and its register bank and comparator
`timescale 1ns/1ns

interface eimg_bank_if;
	logic wrEn;
	logic [5:0] wrAdr;
	logic [31:0] wrData;
	logic wrOk;
	logic [5:0] rdAdr;
	logic [31:0] rdData;
	logic rdOk;
	logic [31:0] posVal;
	logic [31:0] cmp2Val;
	modport top (output wrEn, wrAdr, wrData, rdAdr, posVal, input wrOk, rdData, rdOk, cmp2Val);
	modport bank (input wrEn, wrAdr, wrData, rdAdr, posVal, output wrOk, rdData, rdOk, cmp2Val);
endinterface

interface eimg_cmp_if;
	logic [31:0] posVal;
	logic posValid;
	logic [31:0] cmp2Val;
	logic up;
	logic down;
	logic atOrAbove;
	modport top (output posVal, posValid, cmp2Val, input up, down, atOrAbove);
	modport cmp (input posVal, posValid, cmp2Val, output up, down, atOrAbove);
endinterface

// file: hw/eimg_regbank.sv
// register bank addressed by the controller telegrams
`timescale 1ns/1ns

module eimg_regbank (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	eimg_bank_if.bank bus // read and write requests
);
	logic [31:0] rwQ [eimg_pkg::NUM_RW];

	// ----------------------------------------
	// writable entries, one per index
	// ----------------------------------------
	for (genvar i = 0; i < eimg_pkg::NUM_RW; i++) begin : gRw
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				rwQ[i] <= eimg_pkg::RW_RST;
			end else if (bus.wrEn && bus.wrAdr == eimg_pkg::REG_RW_BASE + 6'(i)) begin
				rwQ[i] <= bus.wrData;
			end
		end
	end

	// address decode: position is read only, entries 1 and 2 read and write, the rest is refused
	always_comb begin
		logic [5:0] rdOff;
		logic [5:0] wrOff;
		rdOff = bus.rdAdr - eimg_pkg::REG_RW_BASE;
		wrOff = bus.wrAdr - eimg_pkg::REG_RW_BASE;
		bus.wrOk = (bus.wrAdr >= eimg_pkg::REG_RW_BASE) && (wrOff < 6'(eimg_pkg::NUM_RW));
		bus.rdOk = 1'b0;
		bus.rdData = 32'h0000_0000;
		if (bus.rdAdr == eimg_pkg::REG_POS_IDX) begin
			bus.rdOk = 1'b1;
			bus.rdData = bus.posVal;
		end else if (bus.rdAdr >= eimg_pkg::REG_RW_BASE && rdOff < 6'(eimg_pkg::NUM_RW)) begin
			bus.rdOk = 1'b1;
			bus.rdData = rwQ[rdOff[0]];
		end
	end

	// first writable entry is the second compare value
	assign bus.cmp2Val = rwQ[0];
endmodule

// file: hw/eimg_compare.sv
// count direction and relational compare of the encoder position
`timescale 1ns/1ns

module eimg_compare (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	eimg_cmp_if.cmp cmp // position in, results out
);
	logic [31:0] lastPosQ;
	logic upQ;
	logic downQ;
	logic geQ;

	// direction judged between two successive samples
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lastPosQ <= 32'h0000_0000;
			upQ <= 1'b0;
			downQ <= 1'b0;
		end else if (cmp.posValid) begin
			lastPosQ <= cmp.posVal;
			upQ <= cmp.posVal > lastPosQ;
			downQ <= cmp.posVal < lastPosQ;
		end
	end

	// compared every cycle, since a telegram write may move the compare value
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			geQ <= 1'b0;
		end else begin
			geQ <= cmp.posVal >= cmp.cmp2Val;
		end
	end

	assign cmp.up = upQ;
	assign cmp.down = downQ;
	assign cmp.atOrAbove = geQ;
endmodule

// file: sim/eimg_top_asserts.sv
// port assertions for the encoder input image block
`timescale 1ns/1ns

module eimg_checker (
	input wire logic ref_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic telStrobe, // telegram pulse
	input wire logic [63:0] telOut, // controller output image
	input wire logic [63:0] telIn, // returned input image
	input wire logic telInValid, // image refreshed pulse
	input wire logic [3:0] encStatus // encoder status bits
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// telegram answer
	// ----------------------------------------
	a_valid_answer: assert property (telStrobe |=> telInValid)
		else $error("no image after telegram");
	a_valid_cause: assert property (telInValid |-> $past(telStrobe))
		else $error("image pulse without telegram");
	a_refused_zero: assert property (telInValid && telIn[39] |-> telIn[31:0] == 32'h0)
		else $error("refused read carries data");
	a_addr_echo: assert property (telInValid |-> telIn[37:32] == $past(telOut[29:24]))
		else $error("read address not echoed");
	a_busy_tracks: assert property (telInValid |-> telIn[46] == $past(telOut[23]))
		else $error("busy flag not request bit");
	a_done_cause: assert property ($rose(telIn[47]) |-> $past(telStrobe) && $past(telOut[23]))
		else $error("write done without request");

	// ----------------------------------------
	// live bits and held fields
	// ----------------------------------------
	// first edge after reset still shows the reset image, so skip it
	a_status_live: assert property ($past(rst_n) |-> telIn[43:40] == $past(encStatus))
		else $error("encoder status not forwarded");
	a_fields_hold: assert property (!telStrobe |=> $stable({telIn[47:46], telIn[39:0]}))
		else $error("telegram fields moved without telegram");
	a_dir_exclusive: assert property (!(telIn[48] && telIn[49]))
		else $error("up and down both set");
	a_layout_zero: assert property (telIn[63:51] == 13'h0 && telIn[45:44] == 2'h0)
		else $error("reserved image bits set");

	cover property (telInValid && telIn[39]);
	cover property ($rose(telIn[47]));
	cover property (telIn[50] && telIn[48]);
endmodule

bind eimg_top eimg_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .telStrobe(telStrobe),
	.telOut(telOut), .telIn(telIn), .telInValid(telInValid), .encStatus(encStatus));

// file: sim/eimg_ctrl_model.sv
// controller model exchanging telegrams with the input image block
`timescale 1ns/1ns

module eimg_ctrl_model (
	input wire logic ref_clk, // system clock
	output logic telStrobe, // telegram pulse
	output logic [63:0] telOut, // output image
	input wire logic [63:0] telIn, // input image
	input wire logic telInValid // image refreshed
);
	logic [63:0] img;
	logic gotValid;

	// idle until the first exchange
	initial begin
		telStrobe = 1'b0;
		telOut = 64'h0;
	end

	// ----------------------------------------
	// one exchange
	// ----------------------------------------
	// gap makes a slow controller; off the strobe the image is inverted
	// so a design sampling late sees garbage rather than the old value
	task automatic xchg(input logic wr, input logic [5:0] wa, input logic [5:0] ra,
			input logic [31:0] d, input int gap);
		repeat (gap) @(posedge ref_clk);
		telStrobe <= 1'b1;
		telOut <= {d, 2'b00, ra, wr, 1'b0, wa, 16'h0000};
		@(posedge ref_clk);
		telStrobe <= 1'b0;
		telOut <= ~{d, 2'b00, ra, wr, 1'b0, wa, 16'h0000};
		@(posedge ref_clk);
		gotValid = telInValid;
		img = telIn;
	endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the encoder input image block
`timescale 1ns/1ns

module tb_top;
	logic ref_clk;
	logic rst_n;
	logic telStrobe;
	logic [63:0] telOut;
	logic [63:0] telIn;
	logic telInValid;
	logic [31:0] encPos;
	logic encPosValid;
	logic [3:0] encStatus;
	logic [7:0] swAddr;
	logic [31:0] swWrData;
	logic swWr;
	logic swRd;
	logic [31:0] swRdData;
	logic [63:0] im;
	int error_cnt;
	int tests_run;

	eimg_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .telStrobe(telStrobe), .telOut(telOut),
		.telIn(telIn), .telInValid(telInValid), .encPos(encPos), .encPosValid(encPosValid),
		.encStatus(encStatus), .swAddr(swAddr), .swWrData(swWrData), .swWr(swWr),
		.swRd(swRd), .swRdData(swRdData));
	eimg_ctrl_model ctl (.ref_clk(ref_clk), .telStrobe(telStrobe), .telOut(telOut),
		.telIn(telIn), .telInValid(telInValid));

	// 50 MHz
	always #10 ref_clk = ~ref_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// writes come from a slow controller, reads from a prompt one
	task automatic tel(input logic wr, input logic [5:0] wa, input logic [5:0] ra,
			input logic [31:0] d);
		ctl.xchg(wr, wa, ra, d, wr ? 3 : 0);
		chk(ctl.gotValid, 1'b1);
		im = ctl.img;
	endtask

	// up/down and compare land two edges after the sample
	task automatic set_pos(input logic [31:0] v);
		encPos <= v;
		encPosValid <= 1'b1;
		@(posedge ref_clk);
		encPosValid <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
		swAddr <= a;
		swWrData <= d;
		swWr <= 1'b1;
		@(posedge ref_clk);
		swWr <= 1'b0;
	endtask

	task automatic sw_rd(input logic [7:0] a, input logic [31:0] exp);
		swAddr <= a;
		swRd <= 1'b1;
		@(posedge ref_clk);
		swRd <= 1'b0;
		@(posedge ref_clk);
		chk(swRdData, exp);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_read;
		set_pos(32'h0000_1234);
		tel(1'b0, 6'h00, 6'h01, 32'h0);
		chk(im[39:32], 8'h01);
		tel(1'b0, 6'h00, 6'h00, 32'h0);
		chk(im[31:0], 32'h0000_1234);
		tel(1'b0, 6'h00, 6'h03, 32'h0);
		chk(im[31:0], 32'h0);
		chk(im[39:32], 8'h83);
		tel(1'b0, 6'h00, 6'h3F, 32'h0);
		chk(im[39:32], 8'hBF);
	endtask

	// a second request while held must be ignored
	task automatic t_write;
		tel(1'b1, 6'h01, 6'h01, 32'h0000_0100);
		chk(im[31:0], 32'h0);
		chk(im[47:46], 2'b11);
		tel(1'b1, 6'h01, 6'h01, 32'h0000_FFFF);
		chk(im[31:0], 32'h0000_0100);
		chk(im[47:46], 2'b11);
		tel(1'b0, 6'h01, 6'h01, 32'h0);
		chk(im[31:0], 32'h0000_0100);
		chk(im[47:46], 2'b10);
		tel(1'b1, 6'h00, 6'h00, 32'h0000_0055);
		chk(im[47:46], 2'b01);
		tel(1'b0, 6'h00, 6'h00, 32'h0);
		chk(im[47:46], 2'b00);
	endtask

	// second compare value is now 0x100; bits are {ge, down, up}
	task automatic t_motion;
		logic [31:0] p [4] = '{32'h0000_0080, 32'h0000_0100, 32'h0000_0100, 32'hFFFF_FFFF};
		logic [2:0] e [4] = '{3'b010, 3'b101, 3'b100, 3'b101};
		for (int i = 0; i < 4; i++) begin
			set_pos(p[i]);
			chk(telIn[50:48], e[i]);
		end
	endtask

	task automatic t_status;
		logic [3:0] s [2] = '{4'hA, 4'h5};
		for (int i = 0; i < 2; i++) begin
			encStatus <= s[i];
			repeat (2) @(posedge ref_clk);
			chk(telIn[43:40], s[i]);
		end
	endtask

	// telegram access switched off and on from the software port
	task automatic t_sw;
		sw_rd(eimg_pkg::SW_CTRL, 32'h0000_0003);
		sw_rd(eimg_pkg::SW_CMP2, 32'h0000_0100);
		sw_rd(8'hFC, 32'h0);
		sw_wr(eimg_pkg::SW_CTRL, 32'h0);
		tel(1'b1, 6'h02, 6'h02, 32'h0000_0007);
		chk(im[39:32], 8'h82);
		chk(im[47:46], 2'b01);
		sw_wr(eimg_pkg::SW_CTRL, 32'h0000_0003);
		tel(1'b0, 6'h00, 6'h02, 32'h0);
		chk(im[31:0], 32'h0);
		chk(im[39:32], 8'h02);
		chk(im[47:46], 2'b00);
		sw_rd(eimg_pkg::SW_POS, 32'hFFFF_FFFF);
		sw_rd(eimg_pkg::SW_STATUS, 32'h0000_0505);
		sw_rd(eimg_pkg::SW_RD_REF, 32'h0000_0003);
		sw_rd(eimg_pkg::SW_WR_REF, 32'h0000_0002);
		sw_rd(eimg_pkg::SW_TEL_CNT, 32'h0000_000B);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		encPos = 32'h0;
		encPosValid = 1'b0;
		encStatus = 4'h0;
		swAddr = 8'h00;
		swWrData = 32'h0;
		swWr = 1'b0;
		swRd = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_read;
		t_write;
		t_motion;
		t_status;
		t_sw;
		print_verdict;
	end

	// the tests need well under 200 cycles; this cuts a hang short
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
endmodule
